/* dpm_pkg.sv */
// shared constants and types for the dual-port mailbox host controller
package dpm_pkg;
  // clock: 20 MHz reference
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_NS = 1_000_000_000 / CLK_HZ;

  // device pin timing in ns, fastest grade
  localparam int T_AH_NS       = 20;   // address hold after select falls
  localparam int SEL_ACCESS_NS = 120;  // select access time
  localparam int T_CEW_NS      = 120;  // select low to end of write
  localparam int STB_WIDTH_NS  = 80;   // write strobe width
  localparam int DATA_SETUP_NS = 40;   // data setup time
  localparam int DATA_HOLD_NS  = 10;   // data hold time
  localparam int STB_FLOAT_NS  = 40;   // strobe to float time
  localparam int T_CER_NS      = 30;   // select recovery
  localparam int T_CEZ_NS      = 90;   // select high to float
  localparam int WR_LAT_NS     = 80;   // write to write latency

  // least times, rounded up to whole cycles
  localparam int AH_C   = (T_AH_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_C  = (SEL_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int CEW_C  = (T_CEW_NS + CLK_NS - 1) / CLK_NS;
  localparam int SWID_C = (STB_WIDTH_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETU_C = (DATA_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int DHLD_C = (DATA_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int FLT_C  = (STB_FLOAT_NS + CLK_NS - 1) / CLK_NS;
  localparam int CER_C  = (T_CER_NS + CLK_NS - 1) / CLK_NS;
  localparam int CEZ_C  = (T_CEZ_NS + CLK_NS - 1) / CLK_NS;
  localparam int WLAT_C = (WR_LAT_NS + CLK_NS - 1) / CLK_NS;
  // strobe must cover width, setup and select-to-end after the hold
  localparam int STB_A = (SWID_C > SETU_C) ? SWID_C : SETU_C;
  localparam int STB_C = (STB_A > CEW_C - AH_C) ? STB_A : CEW_C - AH_C;
  localparam int REC_A = (CER_C > CEZ_C) ? CER_C : CEZ_C;
  localparam int REC_C = (REC_A > WLAT_C) ? REC_A : WLAT_C;

  // counter loads: a phase of n cycles loads n-1
  localparam logic [2:0] HOLD_LD  = 3'(AH_C - 1);
  localparam logic [2:0] READ_LD  = 3'(ACC_C - AH_C - 1);
  localparam logic [2:0] STB_LD   = 3'(STB_C - 1);
  localparam logic [2:0] DHLD_LD  = 3'(DHLD_C - 1);
  localparam logic [2:0] FLT_LD   = 3'(FLT_C - 1);
  localparam logic [2:0] REC_LD   = 3'(REC_C - 1);
  localparam logic [1:0] WLAT_GAP = 2'(WLAT_C);

  // mailbox flag bytes and bits
  localparam logic [8:0] FLAG_X_ADDR = 9'h000;
  localparam logic [8:0] FLAG_Y_ADDR = 9'h1FF;
  localparam int FLAG_REQ  = 0;
  localparam int FLAG_RCPT = 2;

  // host register byte offsets
  localparam logic [4:0] REG_ADDR  = 5'h00;
  localparam logic [4:0] REG_WDATA = 5'h04;
  localparam logic [4:0] REG_CMD   = 5'h08;
  localparam logic [4:0] REG_STAT  = 5'h0C;
  localparam logic [4:0] REG_RDATA = 5'h10;
  localparam logic [4:0] REG_CFG   = 5'h14;

  // command codes in the low bits of the command register
  localparam logic [1:0] CMD_READ  = 2'h0;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_RMW   = 2'h2;
  localparam logic [1:0] CMD_SEND  = 2'h3;

  // pin cycle kinds
  typedef enum logic [1:0] {DPM_RD, DPM_WR, DPM_RMW} dpm_op_t;
endpackage

/* dpm_seq_if.sv */
// request and answer bundle between controller and pin sequencer
`timescale 1ns/1ps
`default_nettype none
interface dpm_seq_if;
  logic             start;  // request held until taken
  dpm_pkg::dpm_op_t op;     // read, write or read-modify-write
  logic [8:0]       addr;   // cycle address
  logic [8:0]       wdata;  // write byte
  logic [8:0]       rdata;  // last byte read
  logic             busy;   // sequencer not idle
  logic             done;   // one-cycle pulse at cycle end
  modport ctl (output start, op, addr, wdata, input rdata, busy, done);
  modport seq (input start, op, addr, wdata, output rdata, busy, done);
endinterface
`default_nettype wire

/* dpm_pin_seq.sv */
// pin sequencer: one multiplexed-bus cycle per request
`timescale 1ns/1ps
`default_nettype none
module dpm_pin_seq (
  // clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_reset_n,
  // request from the controller
  dpm_seq_if.seq          req,
  // device port pins
  input  wire logic [8:0] i_ad,
  output logic [8:0]      o_ad,
  output logic            o_ad_oe,
  output logic            o_ce_n,
  output logic            o_we_n,
  output logic            o_oe_n
);
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_HOLD, S_READ, S_FLOAT, S_STROBE, S_DHOLD, S_REC} dpm_seq_st_t;

  dpm_seq_st_t      state_q;  // cycle phase
  logic [2:0]       cnt_q;    // phase down-counter
  dpm_pkg::dpm_op_t op_q;     // kind of the running cycle
  logic [8:0]       wd_q;     // write byte for the data phase
  logic [8:0]       rd_q;     // captured read byte
  logic             done_q;   // end pulse
  logic [1:0]       wgap_q;   // cycles since last end of write, saturating

  wire cnt_zero = (cnt_q == 3'h0);
  assign req.busy  = (state_q != S_IDLE);
  assign req.done  = done_q;
  assign req.rdata = rd_q;

  // one phase per state; pin outputs change only on transitions
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state_q <= S_IDLE;
      cnt_q   <= 3'h0;
      op_q    <= dpm_pkg::DPM_RD;
      wd_q    <= 9'h000;
      rd_q    <= 9'h000;
      done_q  <= 1'b0;
      o_ad    <= 9'h000;
      o_ad_oe <= 1'b0;
      o_ce_n  <= 1'b1;
      o_we_n  <= 1'b1;
      o_oe_n  <= 1'b1;
    end
    else
    begin
      done_q <= 1'b0;
      cnt_q  <= cnt_q - 3'h1;
      case (state_q)
        S_IDLE:
        begin
          // address goes out a full cycle before select falls
          if (req.start)
          begin
            op_q    <= req.op;
            wd_q    <= req.wdata;
            o_ad    <= req.addr;
            o_ad_oe <= 1'b1;
            state_q <= S_ADDR;
          end
        end
        S_ADDR:
        begin
          // select falling latches the address in the device
          o_ce_n  <= 1'b0;
          cnt_q   <= dpm_pkg::HOLD_LD;
          state_q <= S_HOLD;
        end
        S_HOLD:
        begin
          if (cnt_zero && op_q == dpm_pkg::DPM_WR)
          begin
            // swap the bus from address to data, strobe low (see R3)
            o_ad    <= wd_q;
            o_we_n  <= 1'b0;
            cnt_q   <= dpm_pkg::STB_LD;
            state_q <= S_STROBE;
          end
          else if (cnt_zero)
          begin
            // release the bus on the same edge the gate opens
            o_ad_oe <= 1'b0;
            o_oe_n  <= 1'b0;
            cnt_q   <= dpm_pkg::READ_LD;
            state_q <= S_READ;
          end
        end
        S_READ:
        begin
          if (cnt_zero)
          begin
            rd_q   <= i_ad;
            o_oe_n <= 1'b1;
            if (op_q == dpm_pkg::DPM_RMW)
            begin
              // strobe low with select still low: write to latched address (see R6)
              o_we_n  <= 1'b0;
              cnt_q   <= dpm_pkg::FLT_LD;
              state_q <= S_FLOAT;
            end
            else
            begin
              o_ce_n  <= 1'b1;
              done_q  <= 1'b1;
              cnt_q   <= dpm_pkg::REC_LD;
              state_q <= S_REC;
            end
          end
        end
        S_FLOAT:
        begin
          // device drivers are off now; our data may go on (see R6)
          if (cnt_zero)
          begin
            o_ad    <= wd_q;
            o_ad_oe <= 1'b1;
            cnt_q   <= dpm_pkg::STB_LD;
            state_q <= S_STROBE;
          end
        end
        S_STROBE:
        begin
          // strobe rising ends the write, select stays low (see R4)
          if (cnt_zero)
          begin
            o_we_n  <= 1'b1;
            cnt_q   <= dpm_pkg::DHLD_LD;
            state_q <= S_DHOLD;
          end
        end
        S_DHOLD:
        begin
          // data held past the end of write, then select up (see R3)
          if (cnt_zero)
          begin
            o_ce_n  <= 1'b1;
            o_ad_oe <= 1'b0;
            done_q  <= 1'b1;
            cnt_q   <= dpm_pkg::REC_LD;
            state_q <= S_REC;
          end
        end
        S_REC:
        begin
          // covers select recovery, output float and write spacing (see R4 R22)
          if (cnt_zero)
          begin
            state_q <= S_IDLE;
          end
        end
        default:
        begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // distance between write ends, read only by the checks
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      wgap_q <= 2'h3;
    else if (!o_ce_n && $rose(o_we_n))
      wgap_q <= 2'h0;
    else if (wgap_q != 2'h3)
      wgap_q <= wgap_q + 2'h1;
  end

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_reset_n);

  // a write ends by the strobe rising while select is still low
  sequence s_write_end;
    $rose(o_we_n) && !o_ce_n;
  endsequence
  // data stays driven, then select rises with the bus unchanged
  sequence s_data_held;
    o_ad_oe ##1 ($rose(o_ce_n) && $stable(o_ad));
  endsequence

  AST_DATA_SETUP: assert property (s_write_end |-> $past(o_ad_oe) && o_ad_oe && $stable(o_ad)) // see R3
    else $error("write data not set up before end of write");
  AST_DATA_HOLD: assert property (s_write_end |-> s_data_held) // see R3
    else $error("write data not held after end of write");
  AST_STROBE_WIDTH: assert property (($fell(o_we_n) && !o_ce_n) |-> (!o_we_n)[*2]) // see R4
    else $error("write strobe too short");
  AST_RECOVERY: assert property ($rose(o_ce_n) |-> o_ce_n[*2]) // see R4
    else $error("select recovery violated");
  AST_FLOAT: assert property ((!o_oe_n || $rose(o_oe_n)) |-> !o_ad_oe) // see R6
    else $error("bus driven while device may drive it");
  AST_WRITE_GAP: assert property (s_write_end |-> wgap_q >= dpm_pkg::WLAT_GAP) // see R24 R22
    else $error("write ends closer than write latency");
endmodule
`default_nettype wire

/* dpm_host_ctrl.sv */
// host controller for one port of the dual-port mailbox RAM
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R1 - device writes when select and strobe low
// R2 - select falling latches address on bus
// R3 - host swaps to data, meets setup/hold
// R4 - write ends first rising edge; recovery kept
// R5 - early strobe: cycle starts at select fall
// R6 - read-modify-write: strobe after access, bus floats
// R7 - read-modify-write writes the latched address
// R8 - flag registers written with addresses 000/1FF
// R9 - other port's flag write leaves ours
// R10 - only low three bits reach flags
// R11 - bit0 request, bit1 allow, bit2 receipt
// R12 - allow zero keeps interrupt high
// R13 - allow set with pending request asserts
// R14 - allow cleared deasserts active interrupt
// R15 - request set asserts opposite interrupt
// R16 - request cleared deasserts opposite interrupt
// R17 - receipt set deasserts own interrupt
// R18 - receipt one blocks requests until cleared
// R19 - every byte open to both ports
// R20 - sender checks receipt ready before requesting
// R21 - receiver holds receipt until message read
// R22 - collisions: space write ends apart
// R23 - read when select low, strobe high
// R24 - colliding write ends need write latency
// R25 - port Y flags at 1FF, crossed interrupts
module dpm_host_ctrl (
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset_n,
  // register slave, Avalon-MM
  input  wire logic [4:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  // device port pins
  input  wire logic [8:0]  i_ad,
  output logic [8:0]       o_ad,
  output logic             o_ad_oe,
  output logic             o_ce_n,
  output logic             o_we_n,
  output logic             o_oe_n,
  input  wire logic        i_int_n
);
  typedef enum logic [1:0] {M_IDLE, M_WAIT, M_SREAD, M_SWRITE} dpm_ctl_st_t;

  dpm_seq_if seq ();

  dpm_ctl_st_t      m_state_q;    // command state
  logic [8:0]       addr_q;       // software address register
  logic [8:0]       wdata_q;      // software write byte
  logic             port_sel_q;   // 0: we own port X flags, 1: port Y
  logic             refused_q;    // last command was a send that found receipt busy
  logic             int_q;        // interrupt pin seen low
  logic             start_q;      // request to sequencer, held until taken
  dpm_pkg::dpm_op_t req_op_q;     // request kind
  logic [8:0]       req_addr_q;   // request address
  logic [8:0]       req_wdata_q;  // request write byte

  // address decode used by every register access
  function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
    return a[4:2] == off[4:2];
  endfunction

  // bus decode: a request is taken at the edge where waitrequest is low
  wire        wr_take  = i_avs_write & ~o_avs_waitrequest;
  wire        be_low   = i_avs_byteenable[0];
  wire        be_nine  = &i_avs_byteenable[1:0];
  wire        wr_addr  = wr_take & be_nine & hit(i_avs_address, dpm_pkg::REG_ADDR);
  wire        wr_wdat  = wr_take & be_nine & hit(i_avs_address, dpm_pkg::REG_WDATA);
  wire        wr_cmd   = wr_take & be_low & hit(i_avs_address, dpm_pkg::REG_CMD);
  wire        wr_cfg   = wr_take & be_low & hit(i_avs_address, dpm_pkg::REG_CFG);
  wire [1:0]  cmd      = i_avs_writedata[1:0];
  wire        busy     = (m_state_q != M_IDLE) | start_q | seq.busy;
  // own flag byte: X at the bottom address, Y at the top
  wire [8:0]  flag_addr = port_sel_q ? dpm_pkg::FLAG_Y_ADDR : dpm_pkg::FLAG_X_ADDR; // see R25
  wire        rcpt_busy = seq.rdata[dpm_pkg::FLAG_RCPT];
  // send byte: software tag on top, allow and receipt kept, request set
  wire [8:0]  send_byte = {wdata_q[8:3], seq.rdata[2:1], 1'b1}; // see R10

  // command code to pin cycle kind
  wire dpm_pkg::dpm_op_t cmd_op = (cmd == dpm_pkg::CMD_WRITE) ? dpm_pkg::DPM_WR :
                                  (cmd == dpm_pkg::CMD_RMW)   ? dpm_pkg::DPM_RMW : dpm_pkg::DPM_RD;

  // read selection; unmapped offsets read zero
  wire [31:0] rd_mux =
    hit(i_avs_address, dpm_pkg::REG_ADDR)  ? {23'h000000, addr_q} :
    hit(i_avs_address, dpm_pkg::REG_WDATA) ? {23'h000000, wdata_q} :
    hit(i_avs_address, dpm_pkg::REG_STAT)  ? {29'h00000000, int_q, refused_q, busy} :
    hit(i_avs_address, dpm_pkg::REG_RDATA) ? {23'h000000, seq.rdata} :
    hit(i_avs_address, dpm_pkg::REG_CFG)   ? {31'h00000000, port_sel_q} : 32'h00000000;

  assign seq.start = start_q;
  assign seq.op    = req_op_q;
  assign seq.addr  = req_addr_q;
  assign seq.wdata = req_wdata_q;

  // one wait cycle per access; read data latched as waitrequest drops
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= 32'h00000000;
    end
    else
    begin
      o_avs_waitrequest <= ~((i_avs_read | i_avs_write) & o_avs_waitrequest);
      o_avs_readdata    <= rd_mux;
    end
  end

  // software registers; interrupt pin sampled as a status level
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      addr_q     <= 9'h000;
      wdata_q    <= 9'h000;
      port_sel_q <= 1'b0;
      int_q      <= 1'b0;
    end
    else
    begin
      int_q <= ~i_int_n;
      if (wr_addr)
        addr_q <= i_avs_writedata[8:0];
      if (wr_wdat)
        wdata_q <= i_avs_writedata[8:0];
      if (wr_cfg)
        port_sel_q <= i_avs_writedata[0];
    end
  end

  // command engine; a command while busy is dropped, software polls busy
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      m_state_q   <= M_IDLE;
      start_q     <= 1'b0;
      refused_q   <= 1'b0;
      req_op_q    <= dpm_pkg::DPM_RD;
      req_addr_q  <= 9'h000;
      req_wdata_q <= 9'h000;
    end
    else
    begin
      // the sequencer takes the request when it is idle
      if (start_q && !seq.busy)
        start_q <= 1'b0;
      case (m_state_q)
        M_IDLE:
        begin
          if (wr_cmd && !start_q && !seq.busy)
          begin
            start_q   <= 1'b1;
            refused_q <= 1'b0;
            if (cmd == dpm_pkg::CMD_SEND)
            begin
              // first look at our own receipt flag (see R20)
              req_op_q   <= dpm_pkg::DPM_RD;
              req_addr_q <= flag_addr;
              m_state_q  <= M_SREAD;
            end
            else
            begin
              req_op_q    <= cmd_op;
              req_addr_q  <= addr_q;
              req_wdata_q <= wdata_q;
              m_state_q   <= M_WAIT;
            end
          end
        end
        M_SREAD:
        begin
          if (seq.done && !rcpt_busy)
          begin
            // ready: raise the request, tag names the filled blocks (see R20)
            start_q     <= 1'b1;
            req_op_q    <= dpm_pkg::DPM_WR;
            req_wdata_q <= send_byte;
            m_state_q   <= M_SWRITE;
          end
          else if (seq.done)
          begin
            // receiver still holds its receipt; message must stay untouched (see R21)
            refused_q <= 1'b1;
            m_state_q <= M_IDLE;
          end
        end
        M_WAIT, M_SWRITE:
        begin
          if (seq.done)
            m_state_q <= M_IDLE;
        end
        default:
        begin
          m_state_q <= M_IDLE;
        end
      endcase
    end
  end

  dpm_pin_seq u_seq (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .req       (seq),
    .i_ad      (i_ad),
    .o_ad      (o_ad),
    .o_ad_oe   (o_ad_oe),
    .o_ce_n    (o_ce_n),
    .o_we_n    (o_we_n),
    .o_oe_n    (o_oe_n)
  );

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_reset_n);

  AST_SEND_READY: assert property ((m_state_q == M_SWRITE && start_q) |-> req_op_q == dpm_pkg::DPM_WR && req_wdata_q[dpm_pkg::FLAG_REQ] && !req_wdata_q[dpm_pkg::FLAG_RCPT] && req_addr_q == flag_addr) // see R20
    else $error("request written without ready receipt");
  AST_SEND_REFUSE: assert property ((m_state_q == M_SREAD && seq.done && rcpt_busy) |=> refused_q && m_state_q == M_IDLE && !start_q) // see R21
    else $error("send went on while receipt busy");
endmodule
`default_nettype wire

/* dpm_dev_model.sv */
// behavioural model of the mailbox dual-port RAM, host on port X
`timescale 1ns/1ps
`default_nettype none
module dpm_dev_model (
  // port X pins, driven by the host controller
  input  wire logic       i_ce_n,
  input  wire logic       i_we_n,
  input  wire logic       i_oe_n,
  input  wire logic [8:0] i_ad,
  output logic [8:0]      o_q,
  output logic            o_q_en,
  output logic            o_int_x_n,
  // port Y, an ideal processor writing whole bytes
  input  wire logic       i_y_stb,
  input  wire logic [8:0] i_y_addr,
  input  wire logic [8:0] i_y_data,
  output logic            o_int_y_n
);
  logic [8:0] ram [512];  // one array, open to both ports
  logic [8:0] lat_q;      // address taken as select falls
  logic [2:0] flg_x;      // port X flags: request, allow, receipt
  logic [2:0] flg_y;      // port Y flags, same layout
  wire        wr_act;     // select and strobe both low
  assign wr_act = (i_ce_n === 1'b0) && (i_we_n === 1'b0);

  // the part has no reset; start quiet so stray interrupts show up
  initial
  begin
    for (int i = 0; i < 512; i++)
      ram[i] = 9'(i) ^ 9'h15A;
    flg_x = 3'h0;
    flg_y = 3'h0;
  end

  // only select falling starts a cycle, even with the strobe low early
  always @(negedge i_ce_n)
    lat_q = i_ad;

  // first rising of select or strobe ends the write, target is the latched address
  always @(negedge wr_act)
  begin
    ram[lat_q] = i_ad;
    if (lat_q == 9'h000)
      flg_x = i_ad[2:0];
  end

  // port Y writes; its flags sit at the top address only
  always @(posedge i_y_stb)
  begin
    ram[i_y_addr] = i_y_data;
    if (i_y_addr == 9'h1FF)
      flg_y = i_y_data[2:0];
  end

  // drive only while reading with the gate open; strobe low floats
  assign o_q_en = (i_ce_n === 1'b0) && (i_we_n === 1'b1) && (i_oe_n === 1'b0);
  assign o_q    = ram[lat_q];
  // allowed, requested by the far side, receipt showing ready
  assign #30 o_int_x_n = ~(flg_x[1] & flg_y[0] & ~flg_x[2]);
  assign #30 o_int_y_n = ~(flg_y[1] & flg_x[0] & ~flg_y[2]);
endmodule
`default_nettype wire

/* tb_top.sv */
// self-checking bench: host controller driving the mailbox RAM model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // clock, reset, register bus
  logic        clk;
  logic        rst_n;
  logic [4:0]  a_adr;
  logic        a_rd;
  logic        a_wr;
  logic [31:0] a_wd;
  logic [3:0]  a_be;
  logic [31:0] a_rdat;
  logic        a_wait;
  // device pins; undriven wire shows a changing pattern
  logic [8:0]  h_ad;
  logic        h_oe;
  logic        ce_n;
  logic        we_n;
  logic        oe_n;
  logic        int_x_n;
  logic        int_y_n;
  logic [8:0]  d_q;
  logic        d_en;
  logic [8:0]  flt = 9'h0A5;
  wire  [8:0]  ad_w;
  // far-side processor
  logic        y_stb;
  logic [8:0]  y_adr;
  logic [8:0]  y_dat;
  // results
  logic [31:0] rdv;
  logic [8:0]  ex;
  int          errors;
  int          total_checks;

  assign ad_w = h_oe ? h_ad : (d_en ? d_q : flt);
  always #25 clk = ~clk;
  always @(posedge clk) flt <= ~flt;

  dpm_host_ctrl dpm_host_ctrl_i (
    .i_ref_clk(clk), .i_reset_n(rst_n), .i_avs_address(a_adr), .i_avs_read(a_rd),
    .i_avs_write(a_wr), .i_avs_writedata(a_wd), .i_avs_byteenable(a_be),
    .o_avs_readdata(a_rdat), .o_avs_waitrequest(a_wait), .i_ad(ad_w), .o_ad(h_ad),
    .o_ad_oe(h_oe), .o_ce_n(ce_n), .o_we_n(we_n), .o_oe_n(oe_n), .i_int_n(int_x_n));
  dpm_dev_model dpm_dev_model_i (
    .i_ce_n(ce_n), .i_we_n(we_n), .i_oe_n(oe_n), .i_ad(ad_w), .o_q(d_q), .o_q_en(d_en),
    .o_int_x_n(int_x_n), .i_y_stb(y_stb), .i_y_addr(y_adr), .i_y_data(y_dat),
    .o_int_y_n(int_y_n));

  // verdict and end of run
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // compare one value and keep the tallies
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    a_adr <= a;
    a_wd  <= d;
    a_wr  <= w;
    a_rd  <= ~w;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (a_wait !== 1'b0 && n < 20);
    rdv = a_rdat;
    a_wr <= 1'b0;
    a_rd <= 1'b0;
    if (a_wait !== 1'b0)
    begin
      errors++;
      test_done();
    end
  endtask

  // start a pin cycle; busy must show at once, then clear in bounded time
  task automatic run(input logic [1:0] c);
    int n;
    bus(1'b1, dpm_pkg::REG_CMD, 32'(c));
    bus(1'b0, dpm_pkg::REG_STAT, 32'h0);
    chk("busy", rdv & 32'h1, 32'h1);
    n = 0;
    while (rdv[0] !== 1'b0 && n < 40)
    begin
      bus(1'b0, dpm_pkg::REG_STAT, 32'h0);
      n++;
    end
    if (rdv[0] !== 1'b0)
    begin
      errors++;
      test_done();
    end
  endtask

  // device byte write and read through the controller
  task automatic dw(input logic [8:0] a, input logic [8:0] d);
    bus(1'b1, dpm_pkg::REG_ADDR, 32'(a));
    bus(1'b1, dpm_pkg::REG_WDATA, 32'(d));
    run(dpm_pkg::CMD_WRITE);
  endtask

  task automatic dr(input logic [8:0] a);
    bus(1'b1, dpm_pkg::REG_ADDR, 32'(a));
    run(dpm_pkg::CMD_READ);
    bus(1'b0, dpm_pkg::REG_RDATA, 32'h0);
  endtask

  // far-side write, never near a host write end to one address
  task automatic yw(input logic [8:0] a, input logic [8:0] d);
    @(posedge clk);
    y_adr <= a;
    y_dat <= d;
    y_stb <= 1'b1;
    @(posedge clk);
    y_stb <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic t_regs;
    bus(1'b0, dpm_pkg::REG_STAT, 32'h0);
    chk("stat_reset", rdv, 32'h0);
    bus(1'b1, dpm_pkg::REG_ADDR, 32'hFFFF_F1A5);
    a_be <= 4'h1;
    bus(1'b1, dpm_pkg::REG_ADDR, 32'h0000_0033);
    a_be <= 4'hF;
    bus(1'b0, dpm_pkg::REG_ADDR, 32'h0);
    chk("addr", rdv, 32'h0000_01A5);
    bus(1'b1, 5'h18, 32'h0000_01FF);
    bus(1'b0, 5'h18, 32'h0);
    chk("unmapped", rdv, 32'h0);
    bus(1'b0, dpm_pkg::REG_CMD, 32'h0);
    chk("cmd_read", rdv, 32'h0);
    $display("test regs done");
  endtask

  task automatic t_rw;
    logic [8:0] al [3] = '{9'h001, 9'h1FE, 9'h0AB};
    foreach (al[i])
    begin
      ex = al[i] ^ 9'h155;
      dw(al[i], ex);
      chk("ram_wr", 32'(dpm_dev_model_i.ram[al[i]]), 32'(ex));
      dr(al[i]);
      chk("ram_rd", rdv, 32'(ex));
    end
    yw(9'h100, 9'h0C3);
    dr(9'h100);
    chk("y_byte", rdv, 32'h0C3);
    $display("test rw done");
  endtask

  task automatic t_rmw;
    yw(9'h0AA, 9'h123);
    bus(1'b1, dpm_pkg::REG_ADDR, 32'h0AA);
    bus(1'b1, dpm_pkg::REG_WDATA, 32'h0F0);
    run(dpm_pkg::CMD_RMW);
    bus(1'b0, dpm_pkg::REG_RDATA, 32'h0);
    chk("rmw_old", rdv, 32'h123);
    chk("rmw_new", 32'(dpm_dev_model_i.ram[9'h0AA]), 32'h0F0);
    // a write command while a read runs is dropped
    bus(1'b1, dpm_pkg::REG_WDATA, 32'h055);
    bus(1'b1, dpm_pkg::REG_CMD, 32'(dpm_pkg::CMD_READ));
    run(dpm_pkg::CMD_WRITE);
    chk("busy_drop", 32'(dpm_dev_model_i.ram[9'h0AA]), 32'h0F0);
    $display("test rmw done");
  endtask

  // interrupt pin as reported in status bit 2
  task automatic t_mbox;
    dw(9'h000, 9'h000);
    yw(9'h1FF, 9'h001);
    bus(1'b0, dpm_pkg::REG_STAT, 32'h0);
    chk("int_dis", rdv & 32'h4, 32'h0);
    dw(9'h000, 9'h1FA);
    bus(1'b0, dpm_pkg::REG_STAT, 32'h0);
    chk("int_ena", rdv & 32'h4, 32'h4);
    chk("flags", 32'(dpm_dev_model_i.flg_x), 32'h2);
    yw(9'h000, 9'h000);
    bus(1'b0, dpm_pkg::REG_STAT, 32'h0);
    chk("int_far", rdv & 32'h4, 32'h4);
    dw(9'h000, 9'h000);
    bus(1'b0, dpm_pkg::REG_STAT, 32'h0);
    chk("int_off", rdv & 32'h4, 32'h0);
    dw(9'h000, 9'h002);
    dw(9'h000, 9'h006);
    bus(1'b0, dpm_pkg::REG_STAT, 32'h0);
    chk("int_ack", rdv & 32'h4, 32'h0);
    dw(9'h000, 9'h002);
    bus(1'b0, dpm_pkg::REG_STAT, 32'h0);
    chk("int_rdy", rdv & 32'h4, 32'h4);
    yw(9'h1FF, 9'h000);
    bus(1'b0, dpm_pkg::REG_STAT, 32'h0);
    chk("int_can", rdv & 32'h4, 32'h0);
    $display("test mbox done");
  endtask

  // send: request only when own receipt shows ready, tag in upper bits
  task automatic t_send;
    yw(9'h1FF, 9'h002);
    bus(1'b1, dpm_pkg::REG_WDATA, 32'h1A8);
    run(dpm_pkg::CMD_SEND);
    ex = (9'h1A8 & 9'h1F8) | (9'h002 & 9'h006) | 9'h001;
    chk("send_byte", 32'(dpm_dev_model_i.ram[9'h000]), 32'(ex));
    chk("int_y", 32'(int_y_n), 32'h0);
    chk("not_refused", rdv & 32'h2, 32'h0);
    dw(9'h000, 9'h004);
    bus(1'b1, dpm_pkg::REG_WDATA, 32'h1F8);
    run(dpm_pkg::CMD_SEND);
    chk("refused", rdv & 32'h2, 32'h2);
    chk("no_write", 32'(dpm_dev_model_i.ram[9'h000]), 32'h004);
    // own flags at the top address: send goes to 1FF only
    bus(1'b1, dpm_pkg::REG_CFG, 32'h1);
    bus(1'b0, dpm_pkg::REG_CFG, 32'h0);
    chk("cfg", rdv, 32'h1);
    yw(9'h1FF, 9'h002);
    run(dpm_pkg::CMD_SEND);
    chk("refused_clr", rdv & 32'h2, 32'h0);
    chk("send_top", 32'(dpm_dev_model_i.ram[9'h1FF]), 32'h1FB);
    chk("bottom_kept", 32'(dpm_dev_model_i.ram[9'h000]), 32'h004);
    $display("test send done");
  endtask

  // reset, then the scenarios in turn
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    a_adr = 5'h00;
    a_rd = 1'b0;
    a_wr = 1'b0;
    a_wd = 32'h0;
    a_be = 4'hF;
    y_stb = 1'b0;
    y_adr = 9'h000;
    y_dat = 9'h000;
    errors = 0;
    total_checks = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_rw();
    t_rmw();
    t_mbox();
    t_send();
    test_done();
  end
endmodule
`default_nettype wire
